/* File: hw/osc_pkg.sv */
// Constants and carrier types shared by the oscillator select control files
package osc_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses on the AXI4-Lite bus)
    // ------------------------------------------------------------------
    localparam logic [7:0] OSC_ADDR_CTRL = 8'h00;    // oscillator_control
    localparam logic [7:0] OSC_ADDR_KEY  = 8'h04;    // unlock key register

    // ------------------------------------------------------------------
    // Field positions of oscillator_control
    // ------------------------------------------------------------------
    localparam int OSC_POS_DIVSEL = 24;
    localparam int OSC_POS_DREAM  = 23;
    localparam int OSC_POS_TWOSPD = 21;
    localparam int OSC_POS_CURSRC = 12;
    localparam int OSC_POS_NEWSRC = 8;
    localparam int OSC_POS_LOCK   = 7;
    localparam int OSC_POS_SLEEP  = 4;
    localparam int OSC_POS_CFAIL  = 3;
    localparam int OSC_POS_SECEN  = 1;
    localparam int OSC_POS_SWREQ  = 0;

    // Unimplemented bits 31-27, 22, 20-15, 11, 6-5 and 2
    localparam logic [31:0] OSC_RSVD_MASK = 32'hf85f_8864;

    // ------------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------------
    localparam logic [2:0]  OSC_DIVSEL_RST = 3'h0;   // Divide by one
    localparam logic [2:0]  OSC_SRC_FAST   = 3'h0;   // Divided fast RC
    localparam logic [2:0]  OSC_CURSRC_RST = 3'h0;
    localparam logic [1:0]  OSC_RESP_OKAY  = 2'h0;
    localparam logic [1:0]  OSC_RESP_SLVERR = 2'h2;

    // Unlock key words; values are arbitrary
    localparam logic [31:0] OSC_KEY_FIRST  = 32'h0000_a5a5;
    localparam logic [31:0] OSC_KEY_SECOND = 32'h0000_5a5a;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] target;     // Source to switch to
        logic       twoSpeed;   // Run fast RC until target is ready
    } osc_switch_req_t;

    typedef enum logic [2:0] {
        OSC_SEQ_IDLE   = 3'b001,
        OSC_SEQ_WAIT   = 3'b010,
        OSC_SEQ_FINISH = 3'b100
    } osc_seq_state_t;

endpackage

/* File: hw/osc_switch_seq.sv */
// Clock source switch sequencer with two-speed start
`timescale 1ns/1ps
`default_nettype none

module osc_switch_seq
    import osc_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            rst_b,
    input  wire logic            start,
    input  wire osc_switch_req_t req,
    input  wire logic [7:0]      sourceReady,
    output var  logic            done,
    output var  logic            idle,
    output var  logic            waiting,
    output var  logic [2:0]      target,
    output var  logic [2:0]      sysClockSel
);

    osc_seq_state_t stateReg;

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------

    // Two-speed start parks the system clock on fast RC so the core keeps
    // running while a slow oscillator settles
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stateReg    <= OSC_SEQ_IDLE;
            target      <= OSC_SRC_FAST;
            sysClockSel <= OSC_SRC_FAST;
        end else begin
            case (stateReg)
                OSC_SEQ_IDLE: begin
                    if (start) begin
                        target <= req.target;
                        if (req.twoSpeed && !sourceReady[req.target]) begin
                            sysClockSel <= OSC_SRC_FAST;      // [RQ3]
                            stateReg    <= OSC_SEQ_WAIT;
                        end else begin
                            sysClockSel <= req.target;        // [RQ3]
                            stateReg    <= OSC_SEQ_FINISH;
                        end
                    end
                end
                OSC_SEQ_WAIT: begin
                    if (sourceReady[target]) begin
                        sysClockSel <= target;                // [RQ3]
                        stateReg    <= OSC_SEQ_FINISH;
                    end
                end
                OSC_SEQ_FINISH: begin
                    stateReg <= OSC_SEQ_IDLE;
                end
                default: begin
                    stateReg <= OSC_SEQ_IDLE;
                end
            endcase
        end
    end

    // Status decode
    assign done    = (stateReg == OSC_SEQ_FINISH);
    assign idle    = (stateReg == OSC_SEQ_IDLE);
    assign waiting = (stateReg == OSC_SEQ_WAIT);

endmodule

`default_nettype wire

/* File: hw/osc_select_ctrl.sv */
// Oscillator select control with AXI4-Lite register access
//
// Summary of operation
// RQ1 - Divider code 0..7 divides fast RC by 1,2,4,8,16,32,64,256; default 1.
// RQ2 - Dream mode bit 23 enables dream mode; resets to zero.
// RQ3 - Two-speed bit set: run fast RC until selected clock ready, else direct.
// RQ4 - Bits 14-12 report the clock source actually selected.
// RQ5 - Software must not select reserved new-source codes 110 and 011.
// RQ6 - New-source field loads from the initial source fuse at reset.
// RQ7 - Lock bit 7 freezes the clock and divider selections.
// RQ8 - Sleep enable bit 4 makes a wait instruction enter sleep.
// RQ9 - Clock-fail flag bit 3 is set by hardware on monitor failure.
// RQ10 - Secondary enable bit 1 turns the secondary oscillator on and off.
// RQ11 - Writing one to bit 0 starts a switch; hardware clears it when done.
// RQ12 - Two-speed and switch-request bits power up from the two-speed fuse.
// RQ13 - Control writes are ignored unless the unlock sequence came first.
// RQ14 - Unimplemented control bits read as zero.
// RQ15 - Finished switch copies new source to current; no start while locked.
//
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module osc_select_ctrl
    import osc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Fuses, oscillator status and core events
    input  wire logic [2:0]  initialSourceFuse,
    input  wire logic        twoSpeedStartupFuse,
    input  wire logic [7:0]  sourceReady,
    input  wire logic        clockFailDetect,
    input  wire logic        waitExecuted,
    // Clock controls
    output var  logic [8:0]  fastRcDivRatio,
    output var  logic [2:0]  systemClockSel,
    output var  logic        dreamModeEn,
    output var  logic        secondaryEn,
    output var  logic        sleepEnter,
    output var  logic        idleEnter
);

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------

    // Division ratio for a divider code
    function automatic logic [8:0] osc_div_ratio(input logic [2:0] code);
        osc_div_ratio = (code == 3'h7) ? 9'h100 : (9'h001 << code);   // [RQ1]
    endfunction

    // Merge write data into an old word under byte strobes
    function automatic logic [31:0] osc_merge(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0]  strb);
        logic [31:0] mask;
        mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        osc_merge = (data & mask) | (old & ~mask);
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [2:0]  divSelReg;
    logic        dreamReg;
    logic        twoSpdReg;
    logic [2:0]  curSrcReg;
    logic [2:0]  newSrcReg;
    logic        lockReg;
    logic        sleepEnReg;
    logic        clkFailReg;
    logic        secEnReg;
    logic        swReqReg;
    logic        fuseLoadedReg;
    logic        unlockedReg;
    logic        keyStageReg;
    logic [7:0]  awAddrReg;
    logic        awHeldReg;
    logic [31:0] wDataReg;
    logic [3:0]  wStrbReg;
    logic        wHeldReg;
    logic [31:0] ctrlImage;
    logic [31:0] newImage;
    logic        wrFire;
    logic        wrCtrl;
    logic        wrKey;
    logic        seqStart;
    logic        seqDone;
    logic        seqIdle;
    logic        seqWaiting;
    logic [2:0]  seqTarget;
    logic [2:0]  seqSysSel;
    osc_switch_req_t switchReq;

    // ------------------------------------------------------------------
    // Register image and write decode
    // ------------------------------------------------------------------

    // Unimplemented positions are tied to zero in the image
    assign ctrlImage = (32'(divSelReg)  << OSC_POS_DIVSEL)
                     | (32'(dreamReg)   << OSC_POS_DREAM)
                     | (32'(twoSpdReg)  << OSC_POS_TWOSPD)
                     | (32'(curSrcReg)  << OSC_POS_CURSRC)            // [RQ4]
                     | (32'(newSrcReg)  << OSC_POS_NEWSRC)
                     | (32'(lockReg)    << OSC_POS_LOCK)
                     | (32'(sleepEnReg) << OSC_POS_SLEEP)
                     | (32'(clkFailReg) << OSC_POS_CFAIL)
                     | (32'(secEnReg)   << OSC_POS_SECEN)
                     | (32'(swReqReg)   << OSC_POS_SWREQ);            // [RQ14]

    assign newImage = osc_merge(ctrlImage, wDataReg, wStrbReg);
    assign wrFire   = awHeldReg && wHeldReg && !s_axi_bvalid;
    assign wrCtrl   = wrFire && (awAddrReg == OSC_ADDR_CTRL) && unlockedReg;  // [RQ13]
    assign wrKey    = wrFire && (awAddrReg == OSC_ADDR_KEY);

    // ------------------------------------------------------------------
    // AXI4-Lite write channels
    // ------------------------------------------------------------------

    // Address and data are held separately so either may arrive first
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            awHeldReg     <= 1'b0;
            awAddrReg     <= 8'h00;
            s_axi_awready <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHeldReg     <= 1'b1;
            awAddrReg     <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            awHeldReg     <= 1'b0;
            s_axi_awready <= 1'b1;
        end else if (!awHeldReg && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wHeldReg     <= 1'b0;
            wDataReg     <= 32'h0000_0000;
            wStrbReg     <= 4'h0;
            s_axi_wready <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHeldReg     <= 1'b1;
            wDataReg     <= s_axi_wdata;
            wStrbReg     <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            wHeldReg     <= 1'b0;
            s_axi_wready <= 1'b1;
        end else if (!wHeldReg && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
        end
    end

    // Response; a locked control write still answers OKAY and is dropped
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= OSC_RESP_OKAY;
        end else if (wrFire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awAddrReg == OSC_ADDR_CTRL || awAddrReg == OSC_ADDR_KEY)
                            ? OSC_RESP_OKAY : OSC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------

    // Read data is captured at the address handshake
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= OSC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            if (s_axi_araddr == OSC_ADDR_CTRL) begin
                s_axi_rdata <= ctrlImage;                             // [RQ14]
                s_axi_rresp <= OSC_RESP_OKAY;
            end else if (s_axi_araddr == OSC_ADDR_KEY) begin
                s_axi_rdata <= 32'(unlockedReg);
                s_axi_rresp <= OSC_RESP_OKAY;
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= OSC_RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Unlock sequence
    // ------------------------------------------------------------------

    // Two key words in a row open writes; any other key word closes them
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            keyStageReg <= 1'b0;
            unlockedReg <= 1'b0;
        end else if (wrKey) begin
            keyStageReg <= (wDataReg == OSC_KEY_FIRST);
            unlockedReg <= keyStageReg && (wDataReg == OSC_KEY_SECOND);   // [RQ13]
        end
    end

    // ------------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------------

    // Fuse values are caught on the first edge after reset release
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fuseLoadedReg <= 1'b0;
        end else begin
            fuseLoadedReg <= 1'b1;
        end
    end

    // Clock selections freeze once the lock is set
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            divSelReg <= OSC_DIVSEL_RST;                              // [RQ1]
            newSrcReg <= OSC_SRC_FAST;
            twoSpdReg <= 1'b0;
        end else if (!fuseLoadedReg) begin
            newSrcReg <= initialSourceFuse;                           // [RQ6]
            twoSpdReg <= twoSpeedStartupFuse;                         // [RQ12]
        end else if (wrCtrl && !lockReg) begin                        // [RQ7]
            divSelReg <= newImage[OSC_POS_DIVSEL +: 3];
            newSrcReg <= newImage[OSC_POS_NEWSRC +: 3];
            twoSpdReg <= newImage[OSC_POS_TWOSPD];
        end
    end

    // Lock can only be released by reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lockReg <= 1'b0;
        end else if (wrCtrl && newImage[OSC_POS_LOCK]) begin
            lockReg <= 1'b1;                                          // [RQ7]
        end
    end

    // Power mode and secondary oscillator enables
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dreamReg   <= 1'b0;                                       // [RQ2]
            sleepEnReg <= 1'b0;
            secEnReg   <= 1'b0;
        end else if (wrCtrl) begin
            dreamReg   <= newImage[OSC_POS_DREAM];                    // [RQ2]
            sleepEnReg <= newImage[OSC_POS_SLEEP];                    // [RQ8]
            secEnReg   <= newImage[OSC_POS_SECEN];                    // [RQ10]
        end
    end

    // A failure in the same cycle as a software clear keeps the flag set
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            clkFailReg <= 1'b0;
        end else if (clockFailDetect) begin
            clkFailReg <= 1'b1;                                       // [RQ9]
        end else if (wrCtrl) begin
            clkFailReg <= newImage[OSC_POS_CFAIL];
        end
    end

    // Software request wins over the completion clear in the same cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            swReqReg <= 1'b0;
        end else if (!fuseLoadedReg) begin
            swReqReg <= twoSpeedStartupFuse;                          // [RQ12]
        end else if (wrCtrl && newImage[OSC_POS_SWREQ] && !lockReg) begin
            swReqReg <= 1'b1;                                         // [RQ11]
        end else if (seqDone) begin
            swReqReg <= 1'b0;                                         // [RQ11]
        end
    end

    // ------------------------------------------------------------------
    // Switch sequencing
    // ------------------------------------------------------------------
    assign seqStart         = fuseLoadedReg && swReqReg && !lockReg && seqIdle;  // [RQ15]
    assign switchReq.target = newSrcReg;
    assign switchReq.twoSpeed = twoSpdReg;

    osc_switch_seq u_seq (
        .clk         (clk),
        .rst_b       (rst_b),
        .start       (seqStart),
        .req         (switchReq),
        .sourceReady (sourceReady),
        .done        (seqDone),
        .idle        (seqIdle),
        .waiting     (seqWaiting),
        .target      (seqTarget),
        .sysClockSel (seqSysSel)
    );

    // Current source follows the target once the switch completes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            curSrcReg <= OSC_CURSRC_RST;
        end else if (seqDone) begin
            curSrcReg <= seqTarget;                                   // [RQ15]
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------

    // Registered so every control leaves the block from a flop
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fastRcDivRatio <= 9'h001;
            systemClockSel <= OSC_SRC_FAST;
            dreamModeEn    <= 1'b0;
            secondaryEn    <= 1'b0;
            sleepEnter     <= 1'b0;
            idleEnter      <= 1'b0;
        end else begin
            fastRcDivRatio <= osc_div_ratio(divSelReg);               // [RQ1]
            systemClockSel <= seqSysSel;                              // [RQ3]
            dreamModeEn    <= dreamReg;                               // [RQ2]
            secondaryEn    <= secEnReg;                               // [RQ10]
            sleepEnter     <= waitExecuted && sleepEnReg;             // [RQ8]
            idleEnter      <= waitExecuted && !sleepEnReg;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    chk_div_ratio: assert property (fuseLoadedReg |=> // [RQ1]
        fastRcDivRatio == osc_div_ratio($past(divSelReg)))
        else $error("fast RC ratio does not follow divider code");
    chk_locked_write: assert property (wrFire && !unlockedReg |=> // [RQ13]
        $stable(divSelReg) && $stable(newSrcReg) && $stable(dreamReg) && $stable(lockReg))
        else $error("control changed without unlock");
    chk_lock_freeze: assert property (lockReg && fuseLoadedReg |=> // [RQ7]
        lockReg && $stable(newSrcReg) && $stable(divSelReg))
        else $error("selection changed while locked");
    chk_fail_flag: assert property (clockFailDetect |=> clkFailReg) // [RQ9]
        else $error("clock fail flag not set");
    chk_cur_update: assert property (seqDone |=> curSrcReg == $past(seqTarget)) // [RQ15]
        else $error("current source not updated after switch");
    chk_no_locked_start: assert property (lockReg && seqIdle |=> seqIdle) // [RQ15]
        else $error("switch started while locked");
    chk_two_speed: assert property (seqWaiting |=> systemClockSel == OSC_SRC_FAST) // [RQ3]
        else $error("system clock not on fast RC while waiting");
    chk_sleep_entry: assert property (waitExecuted ##0 sleepEnReg |=> sleepEnter) // [RQ8]
        else $error("wait with sleep enabled did not enter sleep");
    chk_rsvd_zero: assert property (s_axi_rvalid |-> // [RQ14]
        (s_axi_rdata & OSC_RSVD_MASK) == 32'h0)
        else $error("unimplemented bits read nonzero");
    chk_req_clear: assert property (seqDone && !wrCtrl |=> !swReqReg) // [RQ11]
        else $error("switch request not cleared on completion");
    chk_fuse_load: assert property ($rose(fuseLoadedReg) |-> // [RQ6]
        newSrcReg == $past(initialSourceFuse) && swReqReg == $past(twoSpeedStartupFuse)
        && twoSpdReg == $past(twoSpeedStartupFuse))
        else $error("fuse values not loaded after reset");

endmodule

`default_nettype wire

/* File: bench/osc_select_ctrl_bench.sv */
// Self-checking bench for the oscillator select control
`timescale 1ns/1ps
`default_nettype none
module osc_select_ctrl_bench;
    import osc_pkg::*;
    logic        clk, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, twoSpeedStartupFuse, clockFailDetect;
    logic        waitExecuted, dreamModeEn, secondaryEn, sleepEnter, idleEnter;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, sourceReady;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic [2:0]  initialSourceFuse, systemClockSel;
    logic [8:0]  fastRcDivRatio;
    int          failures, tests_run;
    logic        ha, hw, hb;

    osc_select_ctrl i_dut (.clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .initialSourceFuse, .twoSpeedStartupFuse,
        .sourceReady, .clockFailDetect, .waitExecuted, .fastRcDivRatio, .systemClockSel,
        .dreamModeEn, .secondaryEn, .sleepEnter, .idleEnter);

    // Free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // Bus tasks; handshakes are sampled 1 ns after an edge, so they are settled
    // ------------------------------------------------------------------
    task chk(input logic [31:0] act, input logic [31:0] exp);
        tests_run++;
        if (act !== exp) begin
            failures++;
            $display("CHECK FAILED %0t: got %h want %h", $time, act, exp);
        end
    endtask

    task conclude;
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        hb = 1'b0;
        while (!hb) begin
            #1 ha = s_axi_awvalid && s_axi_awready;
            hw = s_axi_wvalid && s_axi_wready;
            hb = s_axi_bvalid && s_axi_bready;
            rsp = s_axi_bresp;
            @(posedge clk);
            if (ha) s_axi_awvalid <= 1'b0;
            if (hw) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
    endtask

    task rdr(input logic [7:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        hb = 1'b0;
        while (!hb) begin
            #1 ha = s_axi_arvalid && s_axi_arready;
            hb = s_axi_rvalid && s_axi_rready;
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge clk);
            if (ha) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
    endtask

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        {failures, tests_run, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, clockFailDetect, waitExecuted, twoSpeedStartupFuse} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        initialSourceFuse = 3'h2;
        sourceReady = 8'hff;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        rdr(OSC_ADDR_CTRL);
        chk(rd, 32'h0000_0200);
        chk(32'(fastRcDivRatio), 32'h1);
        wr(OSC_ADDR_CTRL, 32'h0080_0000);
        rdr(OSC_ADDR_CTRL);
        chk(rd, 32'h0000_0200);
        wr(OSC_ADDR_KEY, OSC_KEY_FIRST);
        wr(OSC_ADDR_KEY, OSC_KEY_SECOND);
        wr(OSC_ADDR_CTRL, 32'h0380_0112 | OSC_RSVD_MASK);
        rdr(OSC_ADDR_CTRL);
        chk(rd, 32'h0380_0112);
        chk(32'({fastRcDivRatio, dreamModeEn, secondaryEn}), 32'h23);
        wr(OSC_ADDR_CTRL, 32'h0380_0113);
        repeat (6) @(posedge clk);
        rdr(OSC_ADDR_CTRL);
        chk(rd, 32'h0380_1112);
        chk(32'(systemClockSel), 32'h1);
        // Wait pulse with sleep enabled gives a sleep entry
        @(posedge clk) waitExecuted <= 1'b1;
        @(posedge clk) waitExecuted <= 1'b0;
        #1 chk(32'({sleepEnter, idleEnter}), 32'h2);
        // Locked: divider, new source and switch start must not move
        wr(OSC_ADDR_CTRL, 32'h0380_0192);
        wr(OSC_ADDR_CTRL, 32'h0080_0293);
        rdr(OSC_ADDR_CTRL);
        chk(rd, 32'h0380_1192);
        wr(8'h08, 32'h1);
        chk(32'(rsp), 32'(OSC_RESP_SLVERR));
        rdr(8'h08);
        chk(rd, 32'h0);
        chk(32'(rsp), 32'(OSC_RESP_SLVERR));
        @(posedge clk) clockFailDetect <= 1'b1;
        @(posedge clk) clockFailDetect <= 1'b0;
        rdr(OSC_ADDR_CTRL);
        chk(rd, 32'h0380_119a);
        // Mid-run reset: two-speed fuse set, secondary target not yet ready
        @(posedge clk) rst_b <= 1'b0;
        twoSpeedStartupFuse <= 1'b1;
        initialSourceFuse <= 3'h4;
        sourceReady <= 8'hef;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        rdr(OSC_ADDR_CTRL);
        chk(rd, 32'h0020_0401);
        chk(32'(systemClockSel), 32'h0);
        sourceReady <= 8'hff;
        repeat (4) @(posedge clk);
        rdr(OSC_ADDR_CTRL);
        chk(rd, 32'h0020_4400);
        chk(32'(systemClockSel), 32'h4);
        // Sleep enable is back to zero, so a wait enters idle
        @(posedge clk) waitExecuted <= 1'b1;
        @(posedge clk) waitExecuted <= 1'b0;
        #1 chk(32'({sleepEnter, idleEnter}), 32'h1);
        conclude();
    end

    // Watchdog well beyond the roughly 90 cycles the tests need
    initial begin
        #50000;
        failures++;
        conclude();
    end
endmodule
`default_nettype wire
